// [design/ufm_pkg.sv]
package ufm_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_BUF = 8'h08;

	// control field positions
	localparam int CTRL_MODE_LO = 0;
	localparam int CTRL_RX_EN = 2;
	localparam int CTRL_ADDR_FILT = 3;
	localparam int CTRL_SYNC_RATE = 4;
	localparam int CTRL_RATE_DBL = 5;
	localparam int CTRL_TX_NINTH = 6;
	localparam logic [6:0] CTRL_RESET = 7'h00;

	// status field positions
	localparam int STAT_RX_DONE = 0;
	localparam int STAT_TX_DONE = 1;
	localparam int STAT_RX_NINTH = 2;
	localparam int STAT_TX_BUSY = 3;
	localparam int STAT_RX_BUSY = 4;

	// mode 0 shift clock dividers
	localparam logic [3:0] M0_DIV_SLOW = 4'hc;
	localparam logic [3:0] M0_DIV_FAST = 4'h2;
	localparam logic [3:0] M0_BITS = 4'h8;

	// mode 2 prescale to the 16x tick: 64/16 and 32/16
	localparam logic [1:0] M2_PRE_SLOW = 2'h3;
	localparam logic [1:0] M2_PRE_FAST = 2'h1;

	// 16x oversampling
	localparam logic [3:0] DIV16_TOP = 4'hf;
	localparam logic [3:0] SMP_A = 4'h7;
	localparam logic [3:0] SMP_B = 4'h8;
	localparam logic [3:0] SMP_C = 4'h9;

	// frame lengths in bits
	localparam logic [3:0] FRAME_10 = 4'ha;
	localparam logic [3:0] FRAME_11 = 4'hb;
	localparam logic [3:0] RX_LAST_BIT = 4'h9;

	typedef enum logic [1:0] {
		MODE_SYNC = 2'b00,
		MODE_ASYNC10 = 2'b01,
		MODE_FIXED11 = 2'b10,
		MODE_TIMED11 = 2'b11
	} ufm_mode_e;
endpackage

// [design/ufm_serial_port.sv]
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
// How it works
// - mode field: 00 sync, 01 async 10-bit, 10 fixed 11-bit, 11 timed 11-bit
// - a buffer write starts a transmission of the written byte unless a send or a mode 0 shift is in progress
// - mode 0 receive starts when receive flag clear and receive enabled
// - async receive starts on a start bit, only if flag clear and enabled
// - mode 0 frame is 8 bits lsb first on rx pin, clock on tx pin
// - mode 0 shift rate is clock/12, or clock/2 with sync rate select
// - mode 0 send starts next clock; data changes on falling edge, zero fill
// - after 8 bits mode 0 send stops and transmit flag sets next clock
// - mode 0 receive latches on rising edge, shifts left, flag sets next clock
// - mode 1 frame: start, 8 data lsb first, stop into receive ninth bit
// - modes 1 and 3 bit rate is timer overflow rate divided by 16
// - async send begins after the next wrap of the divide-by-16 counter
// - async send: start, data, stop; transmit flag sets as stop goes out
// - receive samples at 16x and resets its divider on a falling edge
// - each received bit is majority of samples at states 7, 8 and 9
// - start bit voted high is discarded and the receiver rearms
// - mode 1 load only if flag clear and filter off or stop bit high
// - mode 2 frame has programmable ninth bit copied at buffer write
// - mode 2 bit rate is clock/64, or clock/32 with rate double
// - modes 2/3 load data and ninth bit, gated by flag and address filter
// - mode 3 is mode 2 framing with timer-derived bit rate
module ufm_serial_port (
	// clock, reset, enable
	input wire logic I_CLK,
	input wire logic I_RST,
	input wire logic I_CE,
	// apb slave
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [7:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	// baud timer overflow strobe
	input wire logic I_BAUD_TICK,
	// serial pins
	input wire logic I_RXD,
	output logic O_RXD,
	output logic O_RXD_OE,
	output logic O_TXD
);
	function automatic logic [7:0] rev8(input logic [7:0] v);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 8; i++) begin
			r[i] = v[7 - i];
		end
		return r;
	endfunction

	logic [6:0] ctrl_q;
	logic ri_q;
	logic ti_q;
	logic rb8_q;
	logic [7:0] rx_buf_q;
	logic [31:0] prdata_q;

	logic rxd_s1_q;
	logic rxd_s2_q;
	logic rxd_prev_q;

	logic [10:0] tx_sh_q;
	logic txd_q;
	logic tx_pend_q;
	logic tx_run_q;
	logic [3:0] tx_left_q;
	logic [3:0] tx_div_q;
	logic [1:0] pre_q;

	logic m0_run_q;
	logic m0_tx_q;
	logic m0_fin_q;
	logic [3:0] m0_cnt_q;
	logic [3:0] m0_bit_q;

	logic rx_run_q;
	logic [3:0] rx_div_q;
	logic [3:0] rx_bit_q;
	logic smp_a_q;
	logic smp_b_q;
	logic [8:0] rx_sh_q;

	// register fields
	wire ufm_pkg::ufm_mode_e mode = ufm_pkg::ufm_mode_e'(ctrl_q[1:0]);
	wire rx_en = ctrl_q[ufm_pkg::CTRL_RX_EN];
	wire addr_filt = ctrl_q[ufm_pkg::CTRL_ADDR_FILT];
	wire sync_rate = ctrl_q[ufm_pkg::CTRL_SYNC_RATE];
	wire rate_dbl = ctrl_q[ufm_pkg::CTRL_RATE_DBL];
	wire tx_ninth = ctrl_q[ufm_pkg::CTRL_TX_NINTH];
	wire is_sync = (mode == ufm_pkg::MODE_SYNC);
	wire is_m1 = (mode == ufm_pkg::MODE_ASYNC10);
	wire is_m2 = (mode == ufm_pkg::MODE_FIXED11);

	// apb decode
	// no wait states; unmapped offsets read zero and flag an error
	wire sel_ctrl = (I_PADDR == ufm_pkg::OFS_CTRL);
	wire sel_stat = (I_PADDR == ufm_pkg::OFS_STAT);
	wire sel_buf = (I_PADDR == ufm_pkg::OFS_BUF);
	wire mapped = sel_ctrl | sel_stat | sel_buf;
	wire setup = I_PSEL & ~I_PENABLE & I_CE;
	wire access = I_PSEL & I_PENABLE & I_CE;
	wire wr = access & I_PWRITE;
	wire wr_ctrl = wr & sel_ctrl;
	wire wr_stat = wr & sel_stat;
	wire wr_buf = wr & sel_buf;

	// a write while a frame is in flight is dropped to protect the frame
	wire async_tx_act = tx_pend_q | tx_run_q;
	wire tx_busy = async_tx_act | (m0_run_q & m0_tx_q);
	wire tx_start = wr_buf & ~tx_busy & ~m0_run_q;

	// 16x tick: timer strobe, or fixed prescale in mode 2
	wire [1:0] pre_top = rate_dbl ? ufm_pkg::M2_PRE_FAST : ufm_pkg::M2_PRE_SLOW;
	wire pre_wrap = (pre_q == pre_top);
	wire tick = is_m2 ? pre_wrap : I_BAUD_TICK;
	// one free-running divider: send timing ignores when the buffer was written
	wire tx_wrap = tick & (tx_div_q == ufm_pkg::DIV16_TOP);
	// mode 1 ninth slot carries the stop bit; the count is 10 bits in mode 1 and 11 in modes 2 and 3
	wire [3:0] frame_len = is_m1 ? ufm_pkg::FRAME_10 : ufm_pkg::FRAME_11;

	// mode 0 bit period
	wire [3:0] m0_div = sync_rate ? ufm_pkg::M0_DIV_FAST : ufm_pkg::M0_DIV_SLOW;
	wire [3:0] m0_last = m0_div - 4'h1;
	wire [3:0] m0_rise = {1'b0, m0_div[3:1]} - 4'h1;
	wire m0_rise_now = m0_run_q & (m0_cnt_q == m0_rise);
	wire m0_fall_now = m0_run_q & (m0_cnt_q == m0_last);
	wire m0_done = m0_fall_now & (m0_bit_q == ufm_pkg::M0_BITS - 4'h1);
	// flag still pending in m0_fin_q must also block a restart
	wire m0_rx_start = is_sync & ~m0_run_q & ~m0_fin_q & rx_en & ~ri_q & ~tx_start;

	// shift clock opens low so the first bit gets a full period
	wire m0_go = (tx_start & is_sync) | m0_rx_start;
	// back to idle high on the last falling edge instead of one cycle low
	wire m0_clk_hold = m0_rise_now | (txd_q & ~m0_fall_now);
	wire m0_clk_d = m0_go ? 1'b0 : ((m0_run_q & ~m0_done) ? m0_clk_hold : 1'b1);

	// async receive
	wire rxd_fall = rxd_prev_q & ~rxd_s2_q;
	wire rx_arm = ~is_sync & rx_en & ~ri_q & ~rx_run_q & rxd_fall;
	wire vote = (smp_a_q & smp_b_q) | (smp_a_q & rxd_s2_q) | (smp_b_q & rxd_s2_q);
	wire rx_decide = rx_run_q & tick & (rx_div_q == ufm_pkg::SMP_C);
	wire rx_false_start = rx_decide & (rx_bit_q == 4'h0) & vote;
	wire rx_last = rx_decide & (rx_bit_q == ufm_pkg::RX_LAST_BIT);
	// last bit is the stop in mode 1 and the ninth bit in modes 2 and 3
	wire async_load = rx_last & ~ri_q & (~addr_filt | vote);
	wire m0_rx_load = m0_fin_q & ~m0_tx_q;
	wire rx_load = async_load | m0_rx_load;

	// flag events
	wire async_stop_out = tx_run_q & tx_wrap & (tx_left_q == 4'h1);
	wire ti_set = async_stop_out | (m0_fin_q & m0_tx_q);
	wire ri_clr = wr_stat & I_PWDATA[ufm_pkg::STAT_RX_DONE];
	wire ti_clr = wr_stat & I_PWDATA[ufm_pkg::STAT_TX_DONE];

	// read mux
	wire rx_busy = rx_run_q | (m0_run_q & ~m0_tx_q);
	wire [31:0] stat_word = {27'h0, rx_busy, tx_busy, rb8_q, ti_q, ri_q};
	wire [31:0] rd_word = sel_ctrl ? {25'h0, ctrl_q} :
		sel_stat ? stat_word :
		sel_buf ? {24'h0, rx_buf_q} : 32'h0;

	assign O_PRDATA = prdata_q;
	assign O_PREADY = I_PENABLE & I_CE;
	assign O_PSLVERR = I_PSEL & I_PENABLE & ~mapped;
	assign O_TXD = txd_q;
	assign O_RXD = tx_sh_q[0];
	assign O_RXD_OE = m0_run_q & m0_tx_q;

	// read data captured in setup so the access phase has no wait state
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			prdata_q <= 32'h0;
		end else if (setup) begin
			prdata_q <= rd_word;
		end
	end

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			ctrl_q <= ufm_pkg::CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_q <= I_PWDATA[6:0];
		end
	end

	// write-one-to-clear; a set in the same cycle wins
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			ri_q <= 1'b0;
			ti_q <= 1'b0;
		end else if (I_CE) begin
			ri_q <= rx_load | (ri_q & ~ri_clr);
			ti_q <= ti_set | (ti_q & ~ti_clr);
		end
	end

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			rx_buf_q <= 8'h00;
			rb8_q <= 1'b0;
		end else if (I_CE & async_load) begin
			rx_buf_q <= rx_sh_q[8:1];
			rb8_q <= vote;
		end else if (I_CE & m0_rx_load) begin
			// mode 0 receive leaves the ninth bit as it was
			rx_buf_q <= rev8(rx_sh_q[7:0]);
		end
	end

	// pin synchroniser; only the second stage and its one-cycle delayed copy feed logic
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			rxd_s1_q <= 1'b1;
			rxd_s2_q <= 1'b1;
			rxd_prev_q <= 1'b1;
		end else if (I_CE) begin
			rxd_s1_q <= I_RXD;
			rxd_s2_q <= rxd_s1_q;
			rxd_prev_q <= rxd_s2_q;
		end
	end

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			pre_q <= 2'h0;
			tx_div_q <= 4'h0;
		end else if (I_CE) begin
			pre_q <= pre_wrap ? 2'h0 : pre_q + 2'h1;
			if (tick) begin
				tx_div_q <= tx_div_q + 4'h1;
			end
		end
	end

	// transmit shifter shared by all modes
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			tx_sh_q <= 11'h7ff;
		end else if (I_CE) begin
			if (tx_start & is_sync) begin
				tx_sh_q <= {3'h0, I_PWDATA[7:0]};
			end else if (tx_start) begin
				tx_sh_q <= {1'b1, is_m1 | tx_ninth, I_PWDATA[7:0], 1'b0};
			end else if (m0_fall_now & m0_tx_q) begin
				tx_sh_q <= {1'b0, tx_sh_q[10:1]};
			end else if (tx_wrap & async_tx_act) begin
				tx_sh_q <= {1'b1, tx_sh_q[10:1]};
			end
		end
	end

	// async transmit sequencing
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			tx_pend_q <= 1'b0;
			tx_run_q <= 1'b0;
			tx_left_q <= 4'h0;
		end else if (I_CE) begin
			if (tx_start & ~is_sync) begin
				tx_pend_q <= 1'b1;
			end else if (tx_pend_q & tx_wrap) begin
				tx_pend_q <= 1'b0;
				tx_run_q <= 1'b1;
				tx_left_q <= frame_len - 4'h1;
			end else if (tx_run_q & tx_wrap) begin
				if (tx_left_q == 4'h0) begin
					tx_run_q <= 1'b0;
				end else begin
					tx_left_q <= tx_left_q - 4'h1;
				end
			end
		end
	end

	// tx pin: shift clock in mode 0, serial data otherwise
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			txd_q <= 1'b1;
		end else if (I_CE) begin
			if (is_sync) begin
				txd_q <= m0_clk_d;
			end else if (tx_wrap & tx_pend_q) begin
				txd_q <= tx_sh_q[0];
			end else if (tx_wrap & tx_run_q) begin
				// shifter has already moved on, so bit 0 is the next bit to send
				txd_q <= (tx_left_q == 4'h0) ? 1'b1 : tx_sh_q[0];
			end
		end
	end

	// mode 0 engine
	// limitation: receive restarts by itself while enabled and the flag is clear
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			m0_run_q <= 1'b0;
			m0_tx_q <= 1'b0;
			m0_fin_q <= 1'b0;
			m0_cnt_q <= 4'h0;
			m0_bit_q <= 4'h0;
		end else if (I_CE) begin
			m0_fin_q <= m0_done;
			if (tx_start & is_sync) begin
				m0_run_q <= 1'b1;
				m0_tx_q <= 1'b1;
				m0_cnt_q <= 4'h0;
				m0_bit_q <= 4'h0;
			end else if (m0_rx_start) begin
				m0_run_q <= 1'b1;
				m0_tx_q <= 1'b0;
				m0_cnt_q <= 4'h0;
				m0_bit_q <= 4'h0;
			end else if (m0_done) begin
				m0_run_q <= 1'b0;
			end else if (m0_fall_now) begin
				m0_cnt_q <= 4'h0;
				m0_bit_q <= m0_bit_q + 4'h1;
			end else if (m0_run_q) begin
				m0_cnt_q <= m0_cnt_q + 4'h1;
			end
		end
	end

	// async receive sequencing
	// a dropped enable or a change to mode 0 abandons a half received frame
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			rx_run_q <= 1'b0;
			rx_div_q <= 4'h0;
			rx_bit_q <= 4'h0;
		end else if (I_CE) begin
			if (rx_arm) begin
				rx_run_q <= 1'b1;
				rx_div_q <= 4'h0;
				rx_bit_q <= 4'h0;
			end else if (~rx_en | is_sync | rx_false_start | rx_last) begin
				rx_run_q <= 1'b0;
			end else if (rx_run_q & tick) begin
				rx_div_q <= rx_div_q + 4'h1;
				if (rx_decide) begin
					rx_bit_q <= rx_bit_q + 4'h1;
				end
			end
		end
	end

	// samples and receive shifter
	// the third vote sample is the live synchronised pin, saving a flop
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			smp_a_q <= 1'b1;
			smp_b_q <= 1'b1;
			rx_sh_q <= 9'h000;
		end else if (I_CE) begin
			if (rx_run_q & tick & (rx_div_q == ufm_pkg::SMP_A)) begin
				smp_a_q <= rxd_s2_q;
			end
			if (rx_run_q & tick & (rx_div_q == ufm_pkg::SMP_B)) begin
				smp_b_q <= rxd_s2_q;
			end
			if (m0_rise_now & ~m0_tx_q) begin
				rx_sh_q <= {rx_sh_q[7:0], rxd_s2_q};
			end else if (rx_decide & (rx_bit_q != 4'h0)) begin
				rx_sh_q <= {vote, rx_sh_q[8:1]};
			end
		end
	end
endmodule

// [dv/test_uart_four_mode_serial_port.sv]
`timescale 1ns/1ps
module test_uart_four_mode_serial_port;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [7:0] pa = 8'h00;
	logic [31:0] pd = 32'h0;
	logic tick = 1'b0;
	logic [31:0] prdata, q;
	logic pready, pslverr, rxd_o, oe, txd, line;
	logic [10:0] f;
	logic [7:0] d;
	int miscompares = 0;
	int cmp_count = 0;
	int cyc = 0;
	int m, bt;
	// port drives its pin only while shifting out in mode 0
	wire rxd = oe ? rxd_o : line;
	initial begin
		forever #2 clk = ~clk;
	end
	ufm_serial_port dut (.I_CLK(clk), .I_RST(rst), .I_CE(1'b1), .I_PSEL(psel),
		.I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(pa), .I_PWDATA(pd), .O_PRDATA(prdata),
		.O_PREADY(pready), .O_PSLVERR(pslverr), .I_BAUD_TICK(tick), .I_RXD(rxd),
		.O_RXD(rxd_o), .O_RXD_OE(oe), .O_TXD(txd));
	ufm_partner p (.clk(clk), .sck(txd), .oe(oe), .dout(rxd_o), .line(line));
	task stop_test;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clk) begin
		tick <= ~tick;
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			miscompares++;
			stop_test;
		end
	end
	task chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %0t got %h expected %h", $time, g, e);
		end
	endtask
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pd <= v;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task wflag(input int i);
		do xfer(0, ufm_pkg::OFS_STAT, 0); while (q[i] !== 1'b1);
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		xfer(0, ufm_pkg::OFS_CTRL, 0);
		chk(q, 0);
		xfer(0, 8'h0c, 0);
		chk(q, 0);
		chk(txd, 1);
		for (int r = 0; r < 2; r++) begin
			d = 8'h96 + 8'(r * 33);
			xfer(1, ufm_pkg::OFS_CTRL, r << ufm_pkg::CTRL_SYNC_RATE);
			xfer(1, ufm_pkg::OFS_BUF, d);
			xfer(1, ufm_pkg::OFS_BUF, ~d);
			wflag(1);
			chk(p.cap, d);
			chk(p.ocnt, r ? 16 : 96);
			xfer(1, ufm_pkg::OFS_STAT, 3);
		end
		p.sh = 8'h5a;
		p.m0 = 1'b1;
		xfer(1, ufm_pkg::OFS_CTRL, 32'h4);
		wflag(0);
		xfer(0, ufm_pkg::OFS_BUF, 0);
		chk(q[7:0], 8'h5a);
		p.m0 = 1'b0;
		for (int k = 0; k < 4; k++) begin
			m = k == 3 ? 2 : k + 1;
			bt = k == 3 ? 64 : 32;
			d = 8'h5c + 8'(k);
			xfer(1, ufm_pkg::OFS_CTRL, m | 32'h44 | (k < 3 ? 32'h20 : 0));
			xfer(1, ufm_pkg::OFS_STAT, 3);
			xfer(1, ufm_pkg::OFS_BUF, d);
			p.recv(f, m == 1 ? 10 : 11, bt);
			chk(f, {2'b11, d, 1'b0} & (m == 1 ? 11'h3ff : 11'h7ff));
			xfer(0, ufm_pkg::OFS_STAT, 0);
			chk(q[1], 1);
			d = 8'ha3 ^ 8'(k);
			p.send({1'b1, 1'(k != 1), d, 1'b0}, m == 1 ? 10 : 11, bt);
			wflag(0);
			xfer(0, ufm_pkg::OFS_BUF, 0);
			chk(q[7:0], d);
			xfer(0, ufm_pkg::OFS_STAT, 0);
			chk(q[2], k != 1);
			repeat (bt) @(posedge clk);
		end
		xfer(1, ufm_pkg::OFS_CTRL, 32'h4e);
		xfer(1, ufm_pkg::OFS_STAT, 3);
		p.send({2'b10, 8'h11, 1'b0}, 11, 64);
		repeat (64) @(posedge clk);
		xfer(0, ufm_pkg::OFS_STAT, 0);
		chk(q[0], 0);
		p.send(11'h000, 1, 6);
		p.send(11'h7ff, 1, 64);
		p.send({2'b11, 8'h77, 1'b0}, 11, 64);
		wflag(0);
		xfer(0, ufm_pkg::OFS_BUF, 0);
		chk(q[7:0], 8'h77);
		stop_test;
	end
endmodule

// [dv/ufm_partner.sv]
`timescale 1ns/1ps
module ufm_partner (
	// clock, and shift clock and data from the port
	input wire logic clk,
	input wire logic sck,
	input wire logic oe,
	input wire logic dout,
	// line toward the port
	output logic line
);
	logic m0 = 1'b0;
	logic a_q = 1'b1;
	logic b_q = 1'b1;
	logic sck_q = 1'b1;
	logic oe_q = 1'b0;
	logic [7:0] sh = 8'h00;
	logic [7:0] cap = 8'h00;
	int ocnt = 0;
	assign line = m0 ? b_q : a_q;
	always @(posedge clk) begin
		sck_q <= sck;
		oe_q <= oe;
		// next bit goes out on each falling shift clock
		if (m0 && sck_q && !sck && !oe) begin
			b_q <= sh[0];
			sh <= sh >> 1;
		end
		if (oe && !sck_q && sck) cap <= {dout, cap[7:1]};
		ocnt <= (oe && !oe_q) ? 1 : ocnt + int'(oe);
	end
	task send(input logic [10:0] f, input int n, input int bt);
		for (int i = 0; i < n; i++) begin
			a_q <= f[i];
			repeat (bt) @(posedge clk);
		end
		a_q <= 1'b1;
	endtask
	task recv(output logic [10:0] f, input int n, input int bt);
		f = 11'h000;
		while (sck) @(posedge clk);
		repeat (bt / 2) @(posedge clk);
		for (int i = 0; i < n; i++) begin
			f[i] = sck;
			repeat (bt) @(posedge clk);
		end
	endtask
endmodule

// [dv/ufm_serial_port_checker.sv]
`timescale 1ns/1ps
module ufm_checker (
	// clock, reset, bus
	input wire logic I_CLK,
	input wire logic I_RST,
	input wire logic I_CE,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [7:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	// outputs watched
	input wire logic O_PSLVERR,
	input wire logic O_RXD,
	input wire logic O_RXD_OE,
	input wire logic O_TXD
);
	logic [5:0] ctrl_q;
	wire wr_w = I_PSEL && I_PENABLE && I_PWRITE && I_CE;
	// shadow of the control word, needed to know the mode 0 rate
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) ctrl_q <= 6'h00;
		else if (wr_w && I_PADDR == ufm_pkg::OFS_CTRL) ctrl_q <= I_PWDATA[5:0];
	end
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_RST);
	property p_start;
		$rose(O_RXD_OE) |-> !O_TXD && $past(wr_w && I_PADDR == ufm_pkg::OFS_BUF);
	endproperty
	a_start: assert property (p_start) else $error("bad shift start");
	property p_oe8;
		$rose(O_RXD_OE) |-> O_RXD_OE [*8];
	endproperty
	a_oe8: assert property (p_oe8) else $error("shift too short");
	property p_stab;
		O_RXD_OE && O_TXD && $past(O_TXD) |-> $stable(O_RXD);
	endproperty
	a_stab: assert property (p_stab) else $error("data moved while clock high");
	property p_end;
		$fell(O_RXD_OE) |-> O_TXD;
	endproperty
	a_end: assert property (p_end) else $error("clock not idle at end");
	property p_slow;
		O_RXD_OE && $fell(O_TXD) && !ctrl_q[4] |-> !O_TXD [*6] ##1 O_TXD;
	endproperty
	a_slow: assert property (p_slow) else $error("slow half period");
	property p_fast;
		O_RXD_OE && $fell(O_TXD) && ctrl_q[4] |=> O_TXD;
	endproperty
	a_fast: assert property (p_fast) else $error("fast half period");
	property p_m0;
		O_RXD_OE |-> ctrl_q[1:0] == 2'b00;
	endproperty
	a_m0: assert property (p_m0) else $error("pin driven outside mode 0");
	property p_err;
		I_PSEL && I_PENABLE && I_PADDR == 8'h0c |-> O_PSLVERR;
	endproperty
	a_err: assert property (p_err) else $error("no error on hole");
endmodule
bind ufm_serial_port ufm_checker u_chk (.I_CLK(I_CLK), .I_RST(I_RST), .I_CE(I_CE),
	.I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
	.I_PWDATA(I_PWDATA), .O_PSLVERR(O_PSLVERR), .O_RXD(O_RXD), .O_RXD_OE(O_RXD_OE),
	.O_TXD(O_TXD));
